// ### lcdpd_defines.svh
`ifndef LCDPD_DEFINES_SVH
`define LCDPD_DEFINES_SVH

`define LCDPD_ADDR_W         4
`define LCDPD_DATA_W         8
`define LCDPD_OFS_MAIN       4'h0
`define LCDPD_OFS_SEG_LOW    4'h1
`define LCDPD_OFS_SEG_MID    4'h2
`define LCDPD_OFS_SEG_HIGH   4'h3
`define LCDPD_RST_BYTE       8'h00
`define LCDPD_HIGH_IMPL_MASK 8'h0f
`define LCDPD_FRAME_BIT      7
`define LCDPD_CUR_SEL_HI     6
`define LCDPD_CUR_SEL_LO     5
`define LCDPD_MASTER_BIT     4
`define LCDPD_COM_EN_HI      3
`define LCDPD_SEG_HIGH_EN_HI 3
`define LCDPD_NUM_COM        4
`define LCDPD_NUM_SEG        20

`endif

// ### lcdpd_pkg.sv
package lcdpd_pkg;

  typedef enum logic [1:0] {
    LCDPD_LVL_GND        = 2'h0,
    LCDPD_LVL_THIRD      = 2'h1,
    LCDPD_LVL_TWO_THIRDS = 2'h2,
    LCDPD_LVL_FULL       = 2'h3
  } lcdpd_level_t;

  typedef logic [1:0] lcdpd_cur_sel_t;

endpackage

// ### lcdpd_pin_if.sv
`timescale 1ns/100ps
`default_nettype none

interface lcdpd_pin_if #(parameter int N = 4);
  logic         frame;
  logic         master;
  logic [N-1:0] en;
  logic [N-1:0] data;
  logic [2*N-1:0] level;

  modport drv (output frame, output master, output en, output data, input level);
  modport enc (input frame, input master, input en, input data, output level);
endinterface // lcdpd_pin_if

`default_nettype wire

// ### lcdpd_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdpd_defines.svh"

module lcdpd_regs
  import lcdpd_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic [`LCDPD_ADDR_W-1:0]   reg_addr,
  input  wire logic [`LCDPD_DATA_W-1:0]   reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output var  logic [`LCDPD_DATA_W-1:0]   reg_rdata,
  output var  logic [`LCDPD_DATA_W-1:0]   lcd_main_control,
  output var  logic [`LCDPD_DATA_W-1:0]   lcd_segment_enable_low,
  output var  logic [`LCDPD_DATA_W-1:0]   lcd_segment_enable_mid,
  output var  logic [`LCDPD_DATA_W-1:0]   lcd_segment_enable_high
);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lcd_main_control <= `LCDPD_RST_BYTE;
    end else if (reg_wr && reg_addr == `LCDPD_OFS_MAIN) begin
      lcd_main_control <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lcd_segment_enable_low <= `LCDPD_RST_BYTE;
    end else if (reg_wr && reg_addr == `LCDPD_OFS_SEG_LOW) begin
      lcd_segment_enable_low <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lcd_segment_enable_mid <= `LCDPD_RST_BYTE;
    end else if (reg_wr && reg_addr == `LCDPD_OFS_SEG_MID) begin
      lcd_segment_enable_mid <= reg_wdata;
    end
  end

  // Upper bits are never stored, so they cannot read back as anything but zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lcd_segment_enable_high <= `LCDPD_RST_BYTE;
    end else if (reg_wr && reg_addr == `LCDPD_OFS_SEG_HIGH) begin
      lcd_segment_enable_high <= reg_wdata & `LCDPD_HIGH_IMPL_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= `LCDPD_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `LCDPD_OFS_MAIN:     reg_rdata <= lcd_main_control;
        `LCDPD_OFS_SEG_LOW:  reg_rdata <= lcd_segment_enable_low;
        `LCDPD_OFS_SEG_MID:  reg_rdata <= lcd_segment_enable_mid;
        `LCDPD_OFS_SEG_HIGH: reg_rdata <= lcd_segment_enable_high;
        default:             reg_rdata <= `LCDPD_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `LCDPD_RST_BYTE;
    end
  end

endmodule // lcdpd_regs

`default_nettype wire

// ### lcdpd_level_enc.sv
`timescale 1ns/100ps
`default_nettype none

module lcdpd_level_enc
  import lcdpd_pkg::*;
#(
  parameter int N      = 4,
  parameter bit IS_SEG = 1'b0
)
(
  lcdpd_pin_if.enc p
);

  // Common and segment use mirrored levels, so a set data bit on both gives full panel voltage.
  function automatic lcdpd_level_t pick(input logic master, input logic en, input logic frame,
                                        input logic data);
    lcdpd_level_t lv;
    lv = LCDPD_LVL_GND;
    if (master && en) begin
      if (frame ^ IS_SEG) begin
        lv = data ? LCDPD_LVL_GND : LCDPD_LVL_TWO_THIRDS;
      end else begin
        lv = data ? LCDPD_LVL_FULL : LCDPD_LVL_THIRD;
      end
    end
    return lv;
  endfunction

  always_comb begin
    for (int i = 0; i < N; i++) begin
      p.level[2*i +: 2] = pick(p.master, p.en[i], p.frame, p.data[i]);
    end
  end

endmodule // lcdpd_level_enc

`default_nettype wire

// ### lcdpd_top.sv
// Functional notes
// - Master enable off forces all pins ground.
// - Common enables give pins 0-3 to LCD.
// - Low segment byte enables segments 7-0.
// - Mid segment byte enables segments 15-8.
// - High nibble enables segments 19-16, rest zero.
// - Frame bit selects frame 0 or 1.
// - Frame 0: common full/third, segment ground/two-thirds.
// - Frame 1: common ground/two-thirds, segment full/third.
// - Common levels from port A bits 0,1,2,4; the code takes common pin i from port_a_level_bits[i], bits 0-3.
// - Port direction does not affect LCD driving.
// - Two-bit field selects one of four currents.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lcdpd_defines.svh"

module lcdpd_top
  import lcdpd_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic [`LCDPD_ADDR_W-1:0]      reg_addr,
  input  wire logic [`LCDPD_DATA_W-1:0]      reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  logic [`LCDPD_DATA_W-1:0]      reg_rdata,
  input  wire logic [`LCDPD_NUM_COM-1:0]     port_a_level_bits,
  input  wire logic [`LCDPD_NUM_SEG-1:0]     segment_level_bits,
  output var  logic [2*`LCDPD_NUM_COM-1:0]   common_outputs,
  output var  logic [2*`LCDPD_NUM_SEG-1:0]   segment_outputs,
  output var  logic [`LCDPD_NUM_COM-1:0]     common_pin_select,
  output var  logic [`LCDPD_NUM_SEG-1:0]     segment_pin_select,
  output var  lcdpd_cur_sel_t                drive_current_select,
  output var  logic                          panel_drive_master_enable
);

  logic [`LCDPD_DATA_W-1:0] lcd_main_control;
  logic [`LCDPD_DATA_W-1:0] lcd_segment_enable_low;
  logic [`LCDPD_DATA_W-1:0] lcd_segment_enable_mid;
  logic [`LCDPD_DATA_W-1:0] lcd_segment_enable_high;
  logic                     frame_sel;
  logic                     master_en;
  logic [`LCDPD_NUM_COM-1:0] common_pin_enable;
  logic [`LCDPD_NUM_SEG-1:0] segment_pin_enable;

  lcdpd_pin_if #(.N(`LCDPD_NUM_COM)) com_if ();
  lcdpd_pin_if #(.N(`LCDPD_NUM_SEG)) seg_if ();

  lcdpd_regs u_regs (
    .ref_clk                 (ref_clk),
    .sys_rst                 (sys_rst),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .lcd_main_control        (lcd_main_control),
    .lcd_segment_enable_low  (lcd_segment_enable_low),
    .lcd_segment_enable_mid  (lcd_segment_enable_mid),
    .lcd_segment_enable_high (lcd_segment_enable_high)
  );

  assign frame_sel          = lcd_main_control[`LCDPD_FRAME_BIT];
  assign master_en          = lcd_main_control[`LCDPD_MASTER_BIT];
  assign common_pin_enable  = lcd_main_control[`LCDPD_COM_EN_HI:0];
  assign segment_pin_enable = {lcd_segment_enable_high[`LCDPD_SEG_HIGH_EN_HI:0],
                               lcd_segment_enable_mid, lcd_segment_enable_low};

  // Only data bits, enables, the master bit and the frame bit steer the level; the port direction never enters here.
  assign com_if.frame  = frame_sel;
  assign com_if.master = master_en;
  assign com_if.en     = common_pin_enable;
  assign com_if.data   = port_a_level_bits;
  assign seg_if.frame  = frame_sel;
  assign seg_if.master = master_en;
  assign seg_if.en     = segment_pin_enable;
  assign seg_if.data   = segment_level_bits;

  lcdpd_level_enc #(.N(`LCDPD_NUM_COM), .IS_SEG(1'b0)) u_com_enc (
    .p (com_if.enc)
  );

  lcdpd_level_enc #(.N(`LCDPD_NUM_SEG), .IS_SEG(1'b1)) u_seg_enc (
    .p (seg_if.enc)
  );

  // Registered so the analog switches see one clean change per clock.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      common_outputs  <= '0;
      segment_outputs <= '0;
    end else begin
      common_outputs  <= com_if.level;
      segment_outputs <= seg_if.level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      common_pin_select  <= '0;
      segment_pin_select <= '0;
    end else begin
      common_pin_select  <= master_en ? common_pin_enable : '0;
      segment_pin_select <= master_en ? segment_pin_enable : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      drive_current_select      <= '0;
      panel_drive_master_enable <= 1'b0;
    end else begin
      drive_current_select      <= lcd_main_control[`LCDPD_CUR_SEL_HI:`LCDPD_CUR_SEL_LO];
      panel_drive_master_enable <= master_en;
    end
  end

endmodule // lcdpd_top

`default_nettype wire

// ### lcdpd_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdpd_defines.svh"

module lcdpd_chk
  import lcdpd_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        sys_rst,
  input wire logic [`LCDPD_ADDR_W-1:0]    reg_addr,
  input wire logic [`LCDPD_DATA_W-1:0]    reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [`LCDPD_DATA_W-1:0]    reg_rdata,
  input wire logic [`LCDPD_NUM_COM-1:0]   port_a_level_bits,
  input wire logic [`LCDPD_NUM_SEG-1:0]   segment_level_bits,
  input wire logic [2*`LCDPD_NUM_COM-1:0] common_outputs,
  input wire logic [2*`LCDPD_NUM_SEG-1:0] segment_outputs,
  input wire logic [`LCDPD_NUM_COM-1:0]   common_pin_select,
  input wire logic [`LCDPD_NUM_SEG-1:0]   segment_pin_select,
  input wire lcdpd_cur_sel_t              drive_current_select,
  input wire logic                        panel_drive_master_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence main_wr_s; reg_wr && reg_addr == 4'h0; endsequence
  sequence no_main_wr_s; !(reg_wr && reg_addr == 4'h0); endsequence

  chk_master_off_gnd: assert property (!panel_drive_master_enable |-> common_outputs == 8'h00 && segment_outputs == 40'h0)
    else $error("pins not at ground while master is off");
  chk_com_sel_master: assert property (common_pin_select != 4'h0 |-> panel_drive_master_enable)
    else $error("common pin selected while master is off");
  chk_seg_sel_master: assert property (segment_pin_select != 20'h0 |-> panel_drive_master_enable)
    else $error("segment pin selected while master is off");
  chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_high_nibble_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h3 |-> reg_rdata[7:4] == 4'h0)
    else $error("upper nibble of high segment register not zero");
  chk_frame_polarity: assert property (common_pin_select[0] && segment_pin_select[0]
    |-> common_outputs[0] != segment_outputs[0])
    else $error("common and segment disagree on frame");
  chk_unsel_com_gnd: assert property (!common_pin_select[0] |-> common_outputs[1:0] == 2'h0)
    else $error("unselected common pin not at ground");
  chk_com_data_level: assert property (common_pin_select[0]
    |-> (common_outputs[1] == common_outputs[0]) == $past(port_a_level_bits[0]))
    else $error("common level does not follow its data bit");
  chk_seg_data_level: assert property (segment_pin_select[0]
    |-> (segment_outputs[1] == segment_outputs[0]) == $past(segment_level_bits[0]))
    else $error("segment level does not follow its data bit");
  chk_main_write_out: assert property (main_wr_s ##1 no_main_wr_s |-> ##1
    panel_drive_master_enable == $past(reg_wdata[4], 2) && drive_current_select == $past(reg_wdata[6:5], 2))
    else $error("main control write not reflected");
endmodule // lcdpd_chk

bind lcdpd_top lcdpd_chk i_lcdpd_chk (.*);

`default_nettype wire

// ### lcdpd_panel_model.sv
`timescale 1ns/100ps
`default_nettype none

module lcdpd_panel_model (
  input  wire logic [1:0] com_level,
  input  wire logic [1:0] seg_level,
  output var  logic       pixel_on
);
  // A pixel lights only when it sees the full supply across it; the bias steps stay dark.
  always_comb begin
    pixel_on = (com_level == 2'h3 && seg_level == 2'h0) || (com_level == 2'h0 && seg_level == 2'h3);
  end
endmodule // lcdpd_panel_model

`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pixel_on;
  logic [3:0] reg_addr = 4'h0, pa = 4'h0, csel;
  logic [7:0] reg_wdata = 8'h00, rdata, cout;
  logic [19:0] sg = 20'h0, ssel;
  logic [39:0] sout;
  logic [1:0] cur_sel;
  logic master;
  int error_cnt = 0, num_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  lcdpd_top i_lcdpd_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .port_a_level_bits(pa), .segment_level_bits(sg),
    .common_outputs(cout), .segment_outputs(sout), .common_pin_select(csel), .segment_pin_select(ssel),
    .drive_current_select(cur_sel), .panel_drive_master_enable(master));
  lcdpd_panel_model i_lcdpd_panel_model (.com_level(cout[1:0]), .seg_level(sout[1:0]), .pixel_on(pixel_on));

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask

  function automatic logic [1:0] lvl(input logic s, input logic f, input logic d);
    return (s ^ f) ? (d ? 2'h0 : 2'h2) : (d ? 2'h3 : 2'h1);
  endfunction

  task automatic test_regs();
    for (int a = 0; a < 6; a++) rd(a[3:0], 8'h00);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h0f);
    wr(4'h1, 8'ha5);
    wr(4'h2, 8'h3c);
    rd(4'h1, 8'ha5);
    rd(4'h2, 8'h3c);
    wr(4'h3, 8'h09);
  endtask

  task automatic test_mid_reset();
    wr(4'h0, 8'hff);
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 cmp({csel, ssel, cur_sel, master}, 27'h0);
    cmp({cout, sout}, 48'h0);
    for (int a = 0; a < 4; a++) rd(a[3:0], 8'h00);
  endtask

  task automatic test_levels();
    logic [19:0] sen;
    logic [7:0] ec;
    logic [39:0] es;
    sen = 20'h93ca5;
    // Frame 0 is driven with both data values first, then frame 1 with both.
    for (int f = 0; f < 2; f++) for (int d = 0; d < 2; d++) begin
      @(posedge ref_clk);
      pa <= d[0] ? 4'h9 : 4'h6;
      sg <= d[0] ? 20'ha5c3f : 20'h5a3c0;
      wr(4'h0, {f[0], 2'h0, 1'b1, 4'hb});
      repeat (2) @(posedge ref_clk);
      #1;
      for (int i = 0; i < 4; i++) ec[2*i +: 2] = (4'hb >> i) & 1 ? lvl(1'b0, f[0], pa[i]) : 2'h0;
      for (int i = 0; i < 20; i++) es[2*i +: 2] = sen[i] ? lvl(1'b1, f[0], sg[i]) : 2'h0;
      cmp(csel, 4'hb);
      cmp(master, 1'b1);
      cmp(ssel, sen);
      cmp(cout, ec);
      cmp(sout, es);
      cmp(pixel_on, d[0]);
    end
  endtask

  task automatic test_current_and_off();
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {1'b0, i[1:0], 5'h10});
      repeat (2) @(posedge ref_clk);
      #1 cmp(cur_sel, i[1:0]);
    end
    wr(4'h0, 8'hef);
    repeat (2) @(posedge ref_clk);
    #1 cmp({csel, ssel, master}, 25'h0);
    cmp({cout, sout}, 48'h0);
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_regs();
    test_levels();
    test_current_and_off();
    test_mid_reset();
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
